// ===== bench/spci_pins.sv
// far side: reset pin with pull-up, port A lines and keyboard drivers
`timescale 1ns/1ps
module spci_pins
  import spci_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            rst_ext_n_i,
  input  wire logic            rst_oe_n_i,
  input  wire logic            rst_out_i,
  output logic                 rst_pin_o,
  input  wire logic [PA_W-1:0] ext_en_i,
  input  wire logic [PA_W-1:0] ext_val_i,
  input  wire logic [PA_W-1:0] out_i,
  input  wire logic [PA_W-1:0] oe_n_i,
  input  wire logic [PA_W-1:0] pd_i,
  output logic      [PA_W-1:0] pin_o
);
  logic flip_q = 1'b0;
  always @(posedge clk_i) flip_q <= ~flip_q;
  // pull-up holds the pin high unless either side pulls it low
  assign rst_pin_o = rst_ext_n_i & (rst_oe_n_i | rst_out_i);
  // a floating line without pulldown wanders, so stale values never pass
  always_comb
    for (int i = 0; i < PA_W; i++)
      pin_o[i] = !oe_n_i[i] ? out_i[i] : ext_en_i[i] ? ext_val_i[i]
                 : pd_i[i] ? 1'b0 : flip_q;
endmodule : spci_pins

// ===== bench/spci_top_tb_top.sv
// testbench: clock, reset pin, interrupt and port logic of spci_top
`timescale 1ns/1ps
module spci_top_tb_top;
  import spci_pkg::*;
  localparam logic [3:0] KMASK = 4'h5;
  localparam logic [7:0] MODE  = 8'h20;
  logic clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [4:0] addr_i = 5'h00;
  logic [7:0] wdata_i = 8'h00, port_b_lines_i = 8'h00, rdata_o, r1, r2, r3;
  logic [7:0] port_b_lines_o, port_b_lines_oe_n_o, port_b_pulldown_o;
  logic irq_pin_n_i = 1'b1, irq_hv_sense_i = 1'b1, rst_ext_n = 1'b1;
  logic watchdog_timer_timeout_i = 1'b0, illegal_addr_i = 1'b0;
  logic low_voltage_i = 1'b0, reset_pin_i, reset_pin_o, reset_pin_oe_n_o;
  logic op_clk_o, lpo_active_o, epo_power_down_o, device_reset_n_o;
  logic irq_o, test_mode_o, a, rd_pend = 1'b0;
  logic [PA_W-1:0] port_a_lines_i, port_a_lines_o, port_a_lines_oe_n_o;
  logic [PA_W-1:0] port_a_pulldown_o, ext_val = 6'h00;
  logic [7:0] exp_q[$];
  int n_errors = 0, total_checks = 0, seed = 32'ha5b3, n;

  spci_top #(.KBD_MASK(KMASK)) u_dut (.*, .port_b_alt_en_i(8'h00),
    .port_b_alt_out_i(8'h00), .comp1_out_i(1'b0), .port_c_lines_i(8'h00),
    .port_c_lines_o(), .port_c_lines_oe_n_o(),
    .port_c_pulldown_o());
  spci_pins u_pins (.clk_i(clk_i), .rst_ext_n_i(rst_ext_n),
    .rst_oe_n_i(reset_pin_oe_n_o), .rst_out_i(reset_pin_o),
    .rst_pin_o(reset_pin_i), .ext_en_i(6'h3F), .ext_val_i(ext_val),
    .out_i(port_a_lines_o), .oe_n_i(port_a_lines_oe_n_o),
    .pd_i(port_a_pulldown_o), .pin_o(port_a_lines_i));

  initial forever #25 clk_i = ~clk_i;

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic wr(logic [4:0] ad, logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= ad;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // read data is noted here and compared by the monitor a cycle later
  task automatic rd(logic [4:0] ad, logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= ad;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask : rd
  task automatic hold(bit w, output int k);
    logic v;
    v = w ? op_clk_o : reset_pin_oe_n_o;
    k = 0;
    while ((w ? op_clk_o : reset_pin_oe_n_o) === v && k < 500)
    begin
      tick(1);
      k++;
    end
  endtask : hold
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  always @(posedge clk_i)
  begin
    if (rd_pend)
      chk("rdata", exp_q.pop_front(), rdata_o);
    rd_pend <= rd_i;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    test_done;
  end

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    tick(5);
    irq_hv_sense_i <= 1'b0;
    chk("mode", 8'h01, {7'h0, test_mode_o});
    a = op_clk_o;
    tick(1);
    chk("op_clk", {7'h0, ~a}, {7'h0, op_clk_o});
    rd(ADDR_ISCR, MODE);
    rd(5'h1F, 8'h00);
    rd(ADDR_PDRB, 8'h00);
    $display("test reset done");
    wr(ADDR_ISCR, 8'h80);
    tick(1);
    irq_pin_n_i <= 1'b0;
    #1 chk("irq", 8'h01, {7'h0, irq_o});
    tick(2);
    irq_pin_n_i <= 1'b1;
    tick(1);
    chk("irq", 8'h01, {7'h0, irq_o});
    rd(ADDR_ISCR, MODE | 8'h88);
    wr(ADDR_ISCR, 8'h82);
    tick(1);
    chk("irq", 8'h00, {7'h0, irq_o});
    wr(ADDR_ISCR, 8'h00);
    irq_pin_n_i <= 1'b0;
    tick(1);
    irq_pin_n_i <= 1'b1;
    tick(1);
    chk("irq", 8'h00, {7'h0, irq_o});
    rd(ADDR_ISCR, MODE | 8'h08);
    for (int i = 0; i < KBD_W; i++)
    begin
      wr(ADDR_ISCR, 8'h82);
      ext_val <= 6'(1 << i);
      tick(2);
      chk("kbd_irq", {7'h0, KMASK[i]}, {7'h0, irq_o});
      ext_val <= 6'h00;
    end
    $display("test interrupt done");
    wr(ADDR_CLKCTL, 8'h02);
    rd(ADDR_CLKCTL, 8'h00);
    wr(ADDR_CLKCTL, 8'h03);
    rd(ADDR_CLKCTL, 8'h03);
    tick(1);
    chk("clk_sel", 8'h03, {6'h0, epo_power_down_o, lpo_active_o});
    hold(1'b1, n);
    hold(1'b1, n);
    chk("lpo_half", 8'(LPO_SLOW_CYC), n[7:0]);
    wr(ADDR_CLKCTL, 8'h00);
    $display("test clock done");
    for (int k = 0; k < 4; k++)
    begin
      r1 = $random(seed);
      r2 = $random(seed);
      r3 = $random(seed);
      port_b_lines_i <= r3;
      wr(ADDR_DDRB, r1);
      wr(ADDR_PORTB, r2);
      rd(ADDR_PORTB, (r2 & r1) | (r3 & ~r1));
      chk("pb_oe_n", ~r1, port_b_lines_oe_n_o);
      chk("pb_out", r2 & r1, port_b_lines_o & r1);
    end
    wr(ADDR_PDRB, 8'hFF);
    wr(ADDR_DDRA, 8'h3F);
    wr(ADDR_PORTA, r2);
    rd(ADDR_PORTA, {2'b00, r2[5:0]});
    chk("pa_out", {2'b00, r2[5:0]}, {2'b00, port_a_lines_o});
    chk("pb_pd", ~r1, port_b_pulldown_o);
    $display("test ports done");
    rst_ext_n <= 1'b0;
    tick(3);
    chk("dev_rst", 8'h00, {7'h0, device_reset_n_o});
    chk("pa_oe_n", 8'h3F, {2'b00, port_a_lines_oe_n_o});
    rst_ext_n <= 1'b1;
    tick(4);
    rd(ADDR_DDRA, 8'h00);
    for (int s = 0; s < 3; s++)
    begin
      {low_voltage_i, illegal_addr_i, watchdog_timer_timeout_i} <= 3'(1 << s);
      tick(1);
      {low_voltage_i, illegal_addr_i, watchdog_timer_timeout_i} <= 3'b000;
      chk("rst_oe_n", 8'h00, {7'h0, reset_pin_oe_n_o});
      tick(2);
      chk("dev_rst", 8'h00, {7'h0, device_reset_n_o});
      // two cycles of the drive are already spent when counting starts
      hold(1'b0, n);
      chk("rst_len", 8'(RST_OUT_CYC - 2), n[7:0]);
      tick(4);
    end
    $display("test reset pin done");
    tick(3);
    test_done;
  end
endmodule : spci_top_tb_top

// ===== logic/spci_div.sv
// module: free-running tick divider for the low-power oscillator
`timescale 1ns/1ps
module spci_div
  import spci_pkg::*;
#(
  parameter int unsigned CYC = LPO_SLOW_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);
  localparam int W = $clog2(CYC);
  logic [W-1:0] cnt_q;
  wire          wrap = (cnt_q == W'(CYC - 1));

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_q <= '0;
    else
      cnt_q <= wrap ? '0 : cnt_q + W'(1);
  end

  assign tick_o = wrap;
endmodule : spci_div

// ===== logic/spci_pkg.sv
// package: offsets, fields, reset values and timing of the pin logic
package spci_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [4:0] ADDR_PORTA  = 5'h00;
  localparam logic [4:0] ADDR_PORTB  = 5'h01;
  localparam logic [4:0] ADDR_PORTC  = 5'h02;
  localparam logic [4:0] ADDR_DDRA   = 5'h04;
  localparam logic [4:0] ADDR_DDRB   = 5'h05;
  localparam logic [4:0] ADDR_DDRC   = 5'h06;
  localparam logic [4:0] ADDR_CLKCTL = 5'h07;
  localparam logic [4:0] ADDR_ISCR   = 5'h0D;
  localparam logic [4:0] ADDR_PDRA   = 5'h10;
  localparam logic [4:0] ADDR_PDRB   = 5'h11;

  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  localparam int ISCR_IRQE    = 7;
  localparam int ISCR_OM      = 5;
  localparam int ISCR_IRQF    = 3;
  localparam int ISCR_IRQR    = 1;
  localparam int CLK_LPO_SEL  = 0;
  localparam int CLK_EPO_PD   = 1;
  localparam int CLK_LPO_FAST = 7;
  localparam int PDRA_PDICH   = 7;
  localparam int PDRA_PDICL   = 6;
  localparam int PB_COMP_BIT  = 4;
  localparam logic       IRQE_RST = 1'b0;
  localparam logic [7:0] PORT_RST = 8'h00;

  // ------------------------------------------------------------------
  // widths and build options
  // ------------------------------------------------------------------
  localparam int PA_W  = 6;
  localparam int PB_W  = 8;
  localparam int PC_W  = 8;
  localparam int KBD_W = 4;
  localparam bit            OPT_LPO_FAST   = 1'b0;
  localparam bit            OPT_IRQ_LEVEL  = 1'b1;
  localparam logic [3:0]    OPT_KBD_MASK   = 4'h0;
  localparam bit            OPT_COMP1_PB4  = 1'b0;
  localparam bit            OPT_PD_INHIBIT = 1'b0;
  localparam bit            OPT_PORTC      = 1'b1;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_NS       = 50;
  localparam int unsigned CLK_KHZ      = 20000;
  localparam int unsigned OSC_DIV      = 2;
  localparam int unsigned LPO_SLOW_KHZ = 100;
  localparam int unsigned LPO_FAST_KHZ = 500;
  localparam int unsigned LPO_SLOW_CYC = CLK_KHZ / LPO_SLOW_KHZ;
  localparam int unsigned LPO_FAST_CYC = CLK_KHZ / LPO_FAST_KHZ;
  localparam int unsigned RST_OUT_NS   = 3200;
  localparam int unsigned RST_OUT_CYC  = (RST_OUT_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {RST_IDLE, RST_DRIVE, RST_RELEASE} spci_rst_e;

endpackage : spci_pkg

// ===== logic/spci_port.sv
// module: one bidirectional port with direction, latch and pulldowns
`timescale 1ns/1ps
module spci_port
  import spci_pkg::*;
#(
  parameter int W       = 8,
  parameter bit PRESENT = 1'b1,
  parameter bit PD_INH  = 1'b0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  spci_port_if.port         rif,
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] alt_en_i,
  input  wire logic [W-1:0] alt_out_i,
  output logic      [W-1:0] pin_o,
  output logic      [W-1:0] pin_oe_n_o,
  output logic      [W-1:0] pulldown_o
);
  localparam logic [W-1:0] EN = PRESENT ? '1 : '0;
  logic [W-1:0] dat_q;
  logic [W-1:0] ddr_q;
  logic [W-1:0] pd_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dat_q <= PORT_RST[W-1:0];
      ddr_q <= PORT_RST[W-1:0];
      pd_q  <= PORT_RST[W-1:0];
    end
    else
    begin
      if (rif.wr_dat) dat_q <= rif.wdata[W-1:0];
      if (rif.wr_ddr) ddr_q <= rif.wdata[W-1:0];
      if (rif.wr_pd)  pd_q  <= rif.pd_bits[W-1:0];
    end
  end

  // shared functions take the pin over the port latch
  wire [W-1:0] drive = (ddr_q | alt_en_i) & EN;
  assign pin_o      = (alt_en_i & alt_out_i) | (~alt_en_i & dat_q);
  assign pin_oe_n_o = ~drive;
  // pulldown only on a floating input; the option kills all of them
  assign pulldown_o = pd_q & ~drive & EN & {W{~PD_INH}}; // R16
  assign rif.rd_dat = 8'((((ddr_q & dat_q) | (~ddr_q & pin_i))) & EN);
  assign rif.rd_ddr = 8'(ddr_q & EN);

  AST_PD_INHIBIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    PD_INH |-> pulldown_o == '0) // R16
    else $error("pulldown active while inhibited");
endmodule : spci_port

// ===== logic/spci_port_if.sv
// interface: register access between the top and one port
`timescale 1ns/1ps
interface spci_port_if;
  logic [7:0] wdata;
  logic [7:0] pd_bits;
  logic       wr_dat;
  logic       wr_ddr;
  logic       wr_pd;
  logic [7:0] rd_dat;
  logic [7:0] rd_ddr;
  modport ctrl (output wdata, pd_bits, wr_dat, wr_ddr, wr_pd,
                input  rd_dat, rd_ddr);
  modport port (input  wdata, pd_bits, wr_dat, wr_ddr, wr_pd,
                output rd_dat, rd_ddr);
endinterface : spci_port_if

// ===== logic/spci_top.sv
// module: clock, reset pin, interrupt pin and port pin control
// ------------------------------------------------------------------
// How it works
// R01: operating clock is oscillator divided by two
// R02: software selects internal low-power oscillator
// R03: external oscillator power-down while on low-power
// R04: option fixes low-power rate 100/500 kHz
// R05: reset pin low returns device to startup
// R06: drive reset pin low on internal resets
// R07: request pin reaches interrupt without clock; only the level path does here, edges need the clock to latch
// R08: option chooses edge-only or edge-plus-level
// R09: option ORs keyboard pins into request
// R10: keyboard pins active high and rising
// R11: request sensitivity applies to keyboard pins
// R12: request pin high voltage picks mode
// R13: port A six lines, four keyboard
// R14: port B shared with timer, comparators, serial
// R15: option lets comparator 1 drive bit 4
// R16: software pulldowns, option inhibits all
// R17: port C eight lines, larger package only
// R18: edge latched pending until software acknowledges
// ------------------------------------------------------------------
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module spci_top
  import spci_pkg::*;
#(
  parameter bit         LPO_FAST   = OPT_LPO_FAST,
  parameter bit         IRQ_LEVEL  = OPT_IRQ_LEVEL,
  parameter logic [3:0] KBD_MASK   = OPT_KBD_MASK,
  parameter bit         COMP1_PB4  = OPT_COMP1_PB4,
  parameter bit         PD_INHIBIT = OPT_PD_INHIBIT,
  parameter bit         PORTC_EN   = OPT_PORTC
) (
  input  wire logic            clk_i,
  input  wire logic            reset_n_i,
  input  wire logic [4:0]      addr_i,
  input  wire logic [7:0]      wdata_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  output logic      [7:0]      rdata_o,
  output logic                 op_clk_o,
  output logic                 lpo_active_o,
  output logic                 epo_power_down_o,
  input  wire logic            reset_pin_i,
  output logic                 reset_pin_o,
  output logic                 reset_pin_oe_n_o,
  input  wire logic            watchdog_timer_timeout_i,
  input  wire logic            illegal_addr_i,
  input  wire logic            low_voltage_i,
  output logic                 device_reset_n_o,
  input  wire logic            irq_pin_n_i,
  input  wire logic            irq_hv_sense_i,
  output logic                 irq_o,
  output logic                 test_mode_o,
  input  wire logic [PA_W-1:0] port_a_lines_i,
  output logic      [PA_W-1:0] port_a_lines_o,
  output logic      [PA_W-1:0] port_a_lines_oe_n_o,
  output logic      [PA_W-1:0] port_a_pulldown_o,
  input  wire logic [PB_W-1:0] port_b_lines_i,
  input  wire logic [PB_W-1:0] port_b_alt_en_i,
  input  wire logic [PB_W-1:0] port_b_alt_out_i,
  input  wire logic            comp1_out_i,
  output logic      [PB_W-1:0] port_b_lines_o,
  output logic      [PB_W-1:0] port_b_lines_oe_n_o,
  output logic      [PB_W-1:0] port_b_pulldown_o,
  input  wire logic [PC_W-1:0] port_c_lines_i,
  output logic      [PC_W-1:0] port_c_lines_o,
  output logic      [PC_W-1:0] port_c_lines_oe_n_o,
  output logic      [PC_W-1:0] port_c_pulldown_o
);
  localparam int unsigned LPO_CYC = LPO_FAST ? LPO_FAST_CYC : LPO_SLOW_CYC;

  // ------------------------------------------------------------------
  // reset: power reset synchroniser and reset pin
  // ------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  logic pin_ok_q;
  logic sys_rst_n;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      pin_ok_q <= 1'b0;
    else
      pin_ok_q <= reset_pin_i;
  end

  // a low pin, from outside or from ourselves, resets the core
  assign sys_rst_n        = rst_sync_q & pin_ok_q; // R05
  assign device_reset_n_o = sys_rst_n;

  // ------------------------------------------------------------------
  // reset pin driver
  // ------------------------------------------------------------------
  localparam int RW = $clog2(RST_OUT_CYC + 1);
  spci_rst_e     rst_st_q;
  logic [RW-1:0] rst_cnt_q;
  wire           rst_src = watchdog_timer_timeout_i | illegal_addr_i
                           | low_voltage_i;
  wire           rst_done = (rst_cnt_q == RW'(1));

  // driver lives on the power reset only, else it would cut itself off
  always_ff @(posedge clk_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      rst_st_q  <= RST_IDLE;
      rst_cnt_q <= '0;
    end
    else
    begin
      case (rst_st_q)
        RST_IDLE:
          if (rst_src)
          begin
            rst_st_q  <= RST_DRIVE; // R06
            rst_cnt_q <= RW'(RST_OUT_CYC);
          end
        RST_DRIVE:
        begin
          rst_cnt_q <= rst_cnt_q - RW'(1);
          if (rst_done)
            rst_st_q <= RST_RELEASE;
        end
        RST_RELEASE:
          // wait for the pullup so one source makes one pulse
          if (reset_pin_i && !rst_src)
            rst_st_q <= RST_IDLE;
        default:
          rst_st_q <= RST_IDLE;
      endcase
    end
  end

  assign reset_pin_o      = 1'b0;
  assign reset_pin_oe_n_o = (rst_st_q != RST_DRIVE); // R06

  // ------------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------------
  wire wr_porta = wr_i && (addr_i == ADDR_PORTA);
  wire wr_portb = wr_i && (addr_i == ADDR_PORTB);
  wire wr_portc = wr_i && (addr_i == ADDR_PORTC);
  wire wr_ddra  = wr_i && (addr_i == ADDR_DDRA);
  wire wr_ddrb  = wr_i && (addr_i == ADDR_DDRB);
  wire wr_ddrc  = wr_i && (addr_i == ADDR_DDRC);
  wire wr_clk   = wr_i && (addr_i == ADDR_CLKCTL);
  wire wr_iscr  = wr_i && (addr_i == ADDR_ISCR);
  wire wr_pdra  = wr_i && (addr_i == ADDR_PDRA);
  wire wr_pdrb  = wr_i && (addr_i == ADDR_PDRB);
  wire irq_ack  = wr_iscr && wdata_i[ISCR_IRQR];

  // ------------------------------------------------------------------
  // clock source and divider
  // ------------------------------------------------------------------
  logic lpo_sel_q;
  logic epo_pd_q;
  logic op_q;
  logic lpo_tick;

  spci_div #(
    .CYC     (LPO_CYC) // R04
  ) u_lpo (
    .clk_i   (clk_i),
    .rst_n_i (rst_sync_q),
    .tick_o  (lpo_tick)
  );

  always_ff @(posedge clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      lpo_sel_q <= 1'b0;
      epo_pd_q  <= 1'b0;
    end
    else if (wr_clk)
    begin
      lpo_sel_q <= wdata_i[CLK_LPO_SEL]; // R02
      // power-down is refused unless the low-power source is chosen
      epo_pd_q  <= wdata_i[CLK_EPO_PD] & wdata_i[CLK_LPO_SEL]; // R03
    end
  end

  // each source edge toggles the clock: source divided by two
  always_ff @(posedge clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
      op_q <= 1'b0;
    else if (!lpo_sel_q || lpo_tick)
      op_q <= ~op_q; // R01
  end

  assign op_clk_o         = op_q;
  assign lpo_active_o     = lpo_sel_q;
  assign epo_power_down_o = epo_pd_q; // R03

  // ------------------------------------------------------------------
  // interrupt request and keyboard pins
  // ------------------------------------------------------------------
  logic irqe_q;
  logic act_q;
  logic pend_q;
  logic mode_q;
  logic mode_done_q;

  // keyboard pins are active high, unlike the active-low pin
  wire kbd_act = |(KBD_MASK & port_a_lines_i[KBD_W-1:0]); // R09 R10
  wire req_act = ~irq_pin_n_i | kbd_act;
  wire req_rise = req_act & ~act_q;
  // one sensitivity choice covers both the pin and the keyboard
  wire lvl_act = IRQ_LEVEL & req_act; // R08 R11
  wire irqf    = pend_q | lvl_act;

  always_ff @(posedge clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      irqe_q <= IRQE_RST;
      act_q  <= 1'b0;
      pend_q <= 1'b0;
    end
    else
    begin
      act_q <= req_act;
      if (wr_iscr)
        irqe_q <= wdata_i[ISCR_IRQE];
      // a new edge in the acknowledge cycle stays pending
      if (req_rise)
        pend_q <= 1'b1; // R18
      else if (irq_ack)
        pend_q <= 1'b0; // R18
    end
  end

  // level path is pure logic so a stopped clock still wakes the cpu
  assign irq_o = irqe_q & (pend_q | lvl_act); // R07

  // mode is sampled once, at the first edge after reset release
  always_ff @(posedge clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      mode_q      <= 1'b0;
      mode_done_q <= 1'b0;
    end
    else if (!mode_done_q)
    begin
      mode_q      <= irq_hv_sense_i; // R12
      mode_done_q <= 1'b1;
    end
  end

  assign test_mode_o = mode_q;

  // ------------------------------------------------------------------
  // ports
  // ------------------------------------------------------------------
  spci_port_if pa_if ();
  spci_port_if pb_if ();
  spci_port_if pc_if ();

  assign pa_if.wdata   = wdata_i;
  assign pa_if.pd_bits = wdata_i;
  assign pa_if.wr_dat  = wr_porta;
  assign pa_if.wr_ddr  = wr_ddra;
  assign pa_if.wr_pd   = wr_pdra;
  assign pb_if.wdata   = wdata_i;
  assign pb_if.pd_bits = wdata_i;
  assign pb_if.wr_dat  = wr_portb;
  assign pb_if.wr_ddr  = wr_ddrb;
  assign pb_if.wr_pd   = wr_pdrb;
  assign pc_if.wdata   = wdata_i;
  // one bit enables each nibble of port C
  assign pc_if.pd_bits = {{4{wdata_i[PDRA_PDICH]}}, {4{wdata_i[PDRA_PDICL]}}};
  assign pc_if.wr_dat  = wr_portc;
  assign pc_if.wr_ddr  = wr_ddrc;
  assign pc_if.wr_pd   = wr_pdra;

  // comparator 1 output takes bit 4 when the option is built in
  wire [PB_W-1:0] comp_sel = COMP1_PB4 ? PB_W'(1 << PB_COMP_BIT) : '0;
  wire [PB_W-1:0] pb_alt_en = port_b_alt_en_i | comp_sel; // R14 R15
  wire [PB_W-1:0] pb_alt_out =
    (port_b_alt_out_i & ~comp_sel) | (comp_sel & {PB_W{comp1_out_i}});

  spci_port #(
    .W          (PA_W), // R13
    .PRESENT    (1'b1),
    .PD_INH     (PD_INHIBIT)
  ) u_pa (
    .clk_i      (clk_i),
    .rst_n_i    (sys_rst_n),
    .rif        (pa_if),
    .pin_i      (port_a_lines_i),
    .alt_en_i   ('0),
    .alt_out_i  ('0),
    .pin_o      (port_a_lines_o),
    .pin_oe_n_o (port_a_lines_oe_n_o),
    .pulldown_o (port_a_pulldown_o)
  );

  spci_port #(
    .W          (PB_W),
    .PRESENT    (1'b1),
    .PD_INH     (PD_INHIBIT)
  ) u_pb (
    .clk_i      (clk_i),
    .rst_n_i    (sys_rst_n),
    .rif        (pb_if),
    .pin_i      (port_b_lines_i),
    .alt_en_i   (pb_alt_en),
    .alt_out_i  (pb_alt_out),
    .pin_o      (port_b_lines_o),
    .pin_oe_n_o (port_b_lines_oe_n_o),
    .pulldown_o (port_b_pulldown_o)
  );

  spci_port #(
    .W          (PC_W),
    .PRESENT    (PORTC_EN), // R17
    .PD_INH     (PD_INHIBIT)
  ) u_pc (
    .clk_i      (clk_i),
    .rst_n_i    (sys_rst_n),
    .rif        (pc_if),
    .pin_i      (port_c_lines_i),
    .alt_en_i   ('0),
    .alt_out_i  ('0),
    .pin_o      (port_c_lines_o),
    .pin_oe_n_o (port_c_lines_oe_n_o),
    .pulldown_o (port_c_pulldown_o)
  );

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  logic [7:0] rdata_q;
  wire  [7:0] clk_rd = {LPO_FAST, 5'h00, epo_pd_q, lpo_sel_q};
  wire  [7:0] iscr_rd = {irqe_q, 1'b0, mode_q, 1'b0, irqf, 3'h0};
  // pulldown registers are write-only and read as zero
  wire  [7:0] rd_mux =
    (addr_i == ADDR_PORTA)  ? pa_if.rd_dat :
    (addr_i == ADDR_PORTB)  ? pb_if.rd_dat :
    (addr_i == ADDR_PORTC)  ? pc_if.rd_dat :
    (addr_i == ADDR_DDRA)   ? pa_if.rd_ddr :
    (addr_i == ADDR_DDRB)   ? pb_if.rd_ddr :
    (addr_i == ADDR_DDRC)   ? pc_if.rd_ddr :
    (addr_i == ADDR_CLKCTL) ? clk_rd :
    (addr_i == ADDR_ISCR)   ? iscr_rd : 8'h00;

  always_ff @(posedge clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
      rdata_q <= 8'h00;
    else
      rdata_q <= rd_i ? rd_mux : 8'h00;
  end

  assign rdata_o = rdata_q;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  logic [7:0] lpo_gap_q;
  always_ff @(posedge clk_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      lpo_gap_q <= 8'h00;
    else
      lpo_gap_q <= lpo_tick ? 8'h00 : lpo_gap_q + 8'h01;
  end

  AST_OP_DIV_TWO: assert property (@(posedge clk_i) disable iff (!sys_rst_n)
    (sys_rst_n && !lpo_sel_q ##1 !lpo_sel_q) |-> op_q != $past(op_q)) // R01
    else $error("operating clock not at half the oscillator rate");
  AST_LPO_PERIOD: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    lpo_tick && $past(lpo_gap_q) != 8'h00
      |-> lpo_gap_q == 8'(LPO_CYC - 1)) // R02 R04
    else $error("low-power tick spacing wrong");
  AST_LPO_HOLD: assert property (@(posedge clk_i) disable iff (!sys_rst_n)
    lpo_sel_q && !lpo_tick && !wr_clk |=> op_q == $past(op_q)) // R02
    else $error("operating clock moved without a low-power tick");
  AST_EPO_PD: assert property (@(posedge clk_i) disable iff (!sys_rst_n)
    epo_power_down_o |-> lpo_active_o) // R03
    else $error("oscillator powered down while selected");
  AST_RST_DRIVE: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    rst_st_q == RST_IDLE && rst_src |=> !reset_pin_oe_n_o [*8]) // R06
    else $error("reset pin not driven after internal reset");
  AST_PIN_RESET: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    !reset_pin_i |=> !device_reset_n_o) // R05
    else $error("low reset pin did not reset the core");
  AST_LEVEL_ASYNC: assert property (@(posedge clk_i) disable iff (!sys_rst_n)
    IRQ_LEVEL && irqe_q && !irq_pin_n_i |-> irq_o) // R07 R08
    else $error("level request did not reach the interrupt");
  AST_KBD_POL: assert property (@(posedge clk_i) disable iff (!sys_rst_n)
    irqe_q && irq_pin_n_i && !pend_q
      ##1 kbd_act && !$past(kbd_act) && !irq_ack |=> irq_o) // R09 R10 R11
    else $error("keyboard rising edge lost");
  AST_EDGE_LATCH: assert property (@(posedge clk_i) disable iff (!sys_rst_n)
    req_rise |=> pend_q ##1 (pend_q || $past(irq_ack))) // R18
    else $error("request edge not held pending");
  AST_MODE_HOLD: assert property (@(posedge clk_i) disable iff (!sys_rst_n)
    mode_done_q |=> $stable(mode_q)) // R12
    else $error("mode changed after reset release");
  AST_PB4_COMP: assert property (@(posedge clk_i) disable iff (!sys_rst_n)
    COMP1_PB4 |-> port_b_lines_o[PB_COMP_BIT] == comp1_out_i
      && !port_b_lines_oe_n_o[PB_COMP_BIT]) // R15
    else $error("comparator not on port B bit 4");
  AST_PC_ABSENT: assert property (@(posedge clk_i) disable iff (!sys_rst_n)
    !PORTC_EN |-> port_c_lines_oe_n_o == '1) // R17
    else $error("absent port C drives its pins");

  COV_EDGE_IRQ: cover property (@(posedge clk_i) disable iff (!sys_rst_n)
    req_rise ##1 irq_ack ##1 !pend_q);
  COV_RST_OUT: cover property (@(posedge clk_i) disable iff (!rst_sync_q)
    rst_st_q == RST_DRIVE ##1 rst_st_q == RST_RELEASE);
  COV_LPO_PD: cover property (@(posedge clk_i) disable iff (!sys_rst_n)
    lpo_sel_q && epo_pd_q && lpo_tick);
  COV_SET_CLR: cover property (@(posedge clk_i) disable iff (!sys_rst_n)
    req_rise && irq_ack);
endmodule : spci_top
